// File: verilog/cdm_pkg.sv
// shared constants and types for the core data memory block
`default_nettype none
package cdm_pkg;
   localparam int ADDR_W = 7;
   localparam int GP_DEPTH = 64;
   localparam logic [6:0] ADR_INDIRECT = 7'h00;
   localparam logic [6:0] ADR_POINTER = 7'h01;
   localparam logic [6:0] ADR_WORK = 7'h05;
   localparam logic [6:0] ADR_STATUS = 7'h0A;
   localparam logic [6:0] ADR_IRQ_CTRL = 7'h0B;
   localparam logic [6:0] ADR_GP_LO = 7'h40;
   localparam logic [6:0] ADR_GP_HI = 7'h7F;
   localparam int ST_C = 0;
   localparam int ST_HALF = 1;
   localparam int ST_Z = 2;
   localparam int ST_SWRAP = 3;
   localparam int ST_PWRDN = 4;
   localparam int ST_WDEXP = 5;
   localparam int IC_GIE = 0;
   localparam int IC_EXT_EN = 1;
   localparam int IC_TMR_EN = 2;
   localparam int IC_CNV_EN = 3;
   localparam int IC_EXT_PEND = 4;
   localparam int IC_TMR_PEND = 5;
   localparam int IC_CNV_PEND = 6;
   localparam logic [9:0] VEC_EXT = 10'h004;
   localparam logic [9:0] VEC_TMR = 10'h008;
   localparam logic [9:0] VEC_CNV = 10'h00C;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [9:0] RST_VEC = 10'h000;
   typedef enum logic [4:0] {
      ALU_ADD = 5'h01, ALU_SUB = 5'h02, ALU_LOGIC = 5'h04, ALU_RLC = 5'h08, ALU_RRC = 5'h10
   } cdm_alu_op_type;
   typedef struct packed {
      logic read;
      logic write;
      logic [8:0] address;
      logic [31:0] writedata;
   } cdm_avs_req_type;
   typedef struct packed {
      logic valid;
      cdm_alu_op_type op;
      logic use_carry;
      logic [7:0] a;
      logic [7:0] b;
   } cdm_alu_cmd_type;
   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic half_carry;
      logic z;
      logic sign_wrap;
   } cdm_alu_res_type;
   typedef struct packed {
      logic valid;
      logic set;
      logic [6:0] addr;
      logic [2:0] pos;
   } cdm_bit_cmd_type;
   typedef struct packed {
      logic halt;
      logic wdt_clear;
      logic wdt_timeout;
      logic irq_return;
      logic ack_slot;
      logic stack_full;
      logic timer_ovf;
      logic conv_done;
   } cdm_core_evt_type;
endpackage
`default_nettype wire

// File: verilog/cdm_core_data_memory.sv
// data memory map, alu flags and interrupt logic of the 8-bit core
//
// The Avalon-MM slave port was left to the implementer.
`default_nettype none
module cdm_core_data_memory (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire cdm_pkg::cdm_avs_req_type i_avs,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire cdm_pkg::cdm_alu_cmd_type i_alu,
   input wire cdm_pkg::cdm_bit_cmd_type i_bit,
   input wire cdm_pkg::cdm_core_evt_type i_evt,
   input wire logic i_ext_irq_pin_b,
   output logic o_irq_take,
   output logic [9:0] o_irq_vector,
   output logic o_wake
);
   import cdm_pkg::*;

   logic rst_meta, rst_b;
   logic ext_meta, ext_sync, ext_prev, ext_fall;
   logic [6:0] indirect_pointer;
   logic [7:0] working_register;
   logic flag_c, nibble_wrap_bit, flag_z, signed_wrap_flag, power_down_flag, watchdog_expiry_flag;
   logic gie, ext_en, tmr_en, cnv_en, ext_pend, tmr_pend, cnv_pend;
   logic halted;
   logic [7:0] gp_mem [GP_DEPTH];
   logic [7:0] status_byte, ctrl_byte;
   logic [6:0] bus_idx, bus_eff, bit_eff, wr_addr;
   logic bus_req, bus_go, wr_en;
   logic [7:0] bus_rd, bit_rd, wr_data;
   logic [2:0] req_vec;
   logic take, any_pend;
   cdm_alu_res_type alu_res;

   // indirect through pointer when address zero
   function automatic logic [6:0] eff_addr(input logic [6:0] a, input logic [6:0] p);
      eff_addr = (a == ADR_INDIRECT) ? p : a;
   endfunction

   function automatic logic [7:0] map_read(input logic [6:0] a, input logic [6:0] p,
         input logic [7:0] w, input logic [7:0] s, input logic [7:0] c, input logic [7:0] g);
      if (a >= ADR_GP_LO) begin
         map_read = g;
      end else begin
         unique case (a)
            ADR_POINTER: map_read = {1'b1, p};
            ADR_WORK: map_read = w;
            ADR_STATUS: map_read = s;
            ADR_IRQ_CTRL: map_read = c;
            default: map_read = RST_BYTE;
         endcase
      end
   endfunction

   function automatic cdm_alu_res_type alu_eval(input cdm_alu_cmd_type cmd, input logic cin_q);
      logic [7:0] bb;
      logic cin;
      logic [8:0] sum;
      logic [4:0] lo;
      logic [7:0] low7;
      bb = (cmd.op == ALU_SUB) ? ~cmd.b : cmd.b;
      cin = cmd.use_carry ? cin_q : (cmd.op == ALU_SUB);
      sum = {1'b0, cmd.a} + {1'b0, bb} + {8'h00, cin};
      lo = {1'b0, cmd.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      low7 = {1'b0, cmd.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
      alu_eval = '0;
      unique case (cmd.op)
         ALU_ADD, ALU_SUB: begin
            alu_eval.res = sum[7:0];
            alu_eval.c = sum[8];
            alu_eval.half_carry = lo[4];
            alu_eval.sign_wrap = low7[7] ^ sum[8];
         end
         ALU_LOGIC: alu_eval.res = cmd.a;
         ALU_RLC: begin
            alu_eval.res = {cmd.a[6:0], cin_q};
            alu_eval.c = cmd.a[7];
         end
         ALU_RRC: begin
            alu_eval.res = {cin_q, cmd.a[7:1]};
            alu_eval.c = cmd.a[0];
         end
         default: alu_eval.res = RST_BYTE;
      endcase
      alu_eval.z = (alu_eval.res == RST_BYTE);
   endfunction

   // reset release synchroniser
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta <= 1'b0;
         rst_b <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_b <= rst_meta;
      end
   end

   // external pin synchroniser and edge detect
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_meta <= 1'b1;
         ext_sync <= 1'b1;
         ext_prev <= 1'b1;
      end else begin
         ext_meta <= i_ext_irq_pin_b;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end
   assign ext_fall = ext_prev & ~ext_sync;

   assign status_byte = {2'b00, watchdog_expiry_flag, power_down_flag, signed_wrap_flag, flag_z,
      nibble_wrap_bit, flag_c};
   assign ctrl_byte = {1'b0, cnv_pend, tmr_pend, ext_pend, cnv_en, tmr_en, ext_en, gie};

   // bus side: one wait cycle, access done when waitrequest low
   assign bus_req = i_avs.read | i_avs.write;
   assign bus_go = bus_req & ~o_waitrequest;
   assign bus_idx = i_avs.address[8:2];
   assign bus_eff = eff_addr(bus_idx, indirect_pointer);
   assign bit_eff = eff_addr(i_bit.addr, indirect_pointer);
   assign bus_rd = map_read(bus_eff, indirect_pointer, working_register, status_byte, ctrl_byte,
      gp_mem[bus_eff[5:0]]);
   assign bit_rd = map_read(bit_eff, indirect_pointer, working_register, status_byte, ctrl_byte,
      gp_mem[bit_eff[5:0]]);

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h0000_0000;
      end else begin
         o_waitrequest <= ~(bus_req & o_waitrequest);
         if (i_avs.read && o_waitrequest) begin
            o_readdata <= {24'h00_0000, bus_rd};
         end
      end
   end

   // single write port: bus write first, otherwise bit operation
   always_comb begin
      wr_en = 1'b0;
      wr_addr = bit_eff;
      wr_data = bit_rd;
      wr_data[i_bit.pos] = i_bit.set;
      if (bus_go && i_avs.write) begin
         wr_en = 1'b1;
         wr_addr = bus_eff;
         wr_data = i_avs.writedata[7:0];
      end else if (i_bit.valid) begin
         wr_en = 1'b1;
      end
      if (wr_addr == ADR_INDIRECT) begin
         wr_en = 1'b0;
      end
   end

   assign alu_res = alu_eval(i_alu, flag_c);

   always_ff @(posedge i_clk) begin
      if (wr_en && wr_addr >= ADR_GP_LO) begin
         gp_mem[wr_addr[5:0]] <= wr_data;
      end
   end

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         indirect_pointer <= 7'h00;
      end else if (wr_en && wr_addr == ADR_POINTER) begin
         indirect_pointer <= wr_data[6:0];
      end
   end

   // alu result lands in the working register
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         working_register <= RST_BYTE;
      end else if (i_alu.valid) begin
         working_register <= alu_res.res;
      end else if (wr_en && wr_addr == ADR_WORK) begin
         working_register <= wr_data;
      end
   end

   // arithmetic flags; an alu update overrides a same-cycle write
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         {signed_wrap_flag, flag_z, nibble_wrap_bit, flag_c} <= 4'h0;
      end else if (i_alu.valid) begin
         flag_z <= alu_res.z;
         if (i_alu.op inside {ALU_ADD, ALU_SUB}) begin
            nibble_wrap_bit <= alu_res.half_carry;
            signed_wrap_flag <= alu_res.sign_wrap;
         end
         if (i_alu.op != ALU_LOGIC) begin
            flag_c <= alu_res.c;
         end
      end else if (wr_en && wr_addr == ADR_STATUS) begin
         {signed_wrap_flag, flag_z, nibble_wrap_bit, flag_c} <= wr_data[ST_SWRAP:ST_C];
      end
   end

   // power-down and expiry flags ignore data writes
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_down_flag <= 1'b0;
         watchdog_expiry_flag <= 1'b0;
      end else begin
         if (i_evt.halt) begin
            power_down_flag <= 1'b1;
         end else if (i_evt.wdt_clear) begin
            power_down_flag <= 1'b0;
         end
         if (i_evt.wdt_timeout) begin
            watchdog_expiry_flag <= 1'b1;
         end else if (i_evt.halt || i_evt.wdt_clear) begin
            watchdog_expiry_flag <= 1'b0;
         end
      end
   end

   // interrupt arbitration; stack push of pc alone is the sequencer's
   assign req_vec = {cnv_pend & cnv_en, tmr_pend & tmr_en, ext_pend & ext_en};
   assign take = i_evt.ack_slot & gie & ~i_evt.stack_full & (|req_vec);
   assign any_pend = ext_pend | tmr_pend | cnv_pend;

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         {cnv_en, tmr_en, ext_en} <= 3'b000;
      end else if (wr_en && wr_addr == ADR_IRQ_CTRL) begin
         {cnv_en, tmr_en, ext_en} <= wr_data[IC_CNV_EN:IC_EXT_EN];
      end
   end

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         gie <= 1'b0;
      end else if (take) begin
         gie <= 1'b0;
      end else if (i_evt.irq_return) begin
         gie <= 1'b1;
      end else if (wr_en && wr_addr == ADR_IRQ_CTRL) begin
         gie <= wr_data[IC_GIE];
      end
   end

   // pending flags: a new request wins over any clear
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         {cnv_pend, tmr_pend, ext_pend} <= 3'b000;
      end else begin
         if (ext_fall) begin
            ext_pend <= 1'b1;
         end else if (take && req_vec[0]) begin
            ext_pend <= 1'b0;
         end else if (wr_en && wr_addr == ADR_IRQ_CTRL) begin
            ext_pend <= wr_data[IC_EXT_PEND];
         end
         if (i_evt.timer_ovf) begin
            tmr_pend <= 1'b1;
         end else if (take && req_vec == 3'b010 || take && req_vec == 3'b110) begin
            tmr_pend <= 1'b0;
         end else if (wr_en && wr_addr == ADR_IRQ_CTRL) begin
            tmr_pend <= wr_data[IC_TMR_PEND];
         end
         if (i_evt.conv_done) begin
            cnv_pend <= 1'b1;
         end else if (take && req_vec == 3'b100) begin
            cnv_pend <= 1'b0;
         end else if (wr_en && wr_addr == ADR_IRQ_CTRL) begin
            cnv_pend <= wr_data[IC_CNV_PEND];
         end
      end
   end

   // vector call request to the sequencer
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_irq_take <= 1'b0;
         o_irq_vector <= RST_VEC;
      end else begin
         o_irq_take <= take;
         if (take) begin
            if (req_vec[0]) begin
               o_irq_vector <= VEC_EXT;
            end else if (req_vec[1]) begin
               o_irq_vector <= VEC_TMR;
            end else begin
               o_irq_vector <= VEC_CNV;
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         halted <= 1'b0;
         o_wake <= 1'b0;
      end else begin
         o_wake <= halted & any_pend;
         if (i_evt.halt) begin
            halted <= 1'b1;
         end else if (any_pend) begin
            halted <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_b);

   sequence bus_read_at(logic [6:0] a);
      i_avs.read && !o_waitrequest && bus_eff == a;
   endsequence

   unused_read_a: assert property (
      i_avs.read && !o_waitrequest && bus_eff > ADR_IRQ_CTRL && bus_eff < ADR_GP_LO
      |-> o_readdata == 32'h0000_0000) else $error("unused location read nonzero");
   indirect_zero_a: assert property (
      bus_read_at(ADR_INDIRECT) |-> o_readdata == 32'h0000_0000)
      else $error("indirect read through zero pointer nonzero");
   ptr_msb_a: assert property (
      bus_read_at(ADR_POINTER) |-> o_readdata[7:0] == {1'b1, indirect_pointer})
      else $error("pointer readback wrong");
   status_top_a: assert property (
      bus_read_at(ADR_STATUS) |-> o_readdata[7:6] == 2'b00) else $error("status top bits set");
   pdf_write_a: assert property (
      wr_en && wr_addr == ADR_STATUS && !i_evt.halt && !i_evt.wdt_clear && !i_evt.wdt_timeout
      |=> $stable(power_down_flag) && $stable(watchdog_expiry_flag))
      else $error("status write changed protected flag");
   take_clears_a: assert property (
      take |=> o_irq_take && !gie) else $error("service did not clear global enable");
   full_block_a: assert property (
      i_evt.stack_full |=> !o_irq_take) else $error("interrupt taken with stack full");
   ext_edge_a: assert property (
      $fell(ext_sync) |=> ext_pend) else $error("falling pin edge not latched");
   prio_ext_a: assert property (
      take && req_vec[0] |=> o_irq_vector == VEC_EXT ##1 !o_irq_take)
      else $error("external request lost priority");
   irq_return_instr_a: assert property (
      i_evt.irq_return && !take |=> gie) else $error("interrupt return left enable off");
endmodule // cdm_core_data_memory
`default_nettype wire

// File: bench/cdm_seq_model.sv
// sequencer model: instruction-slot ticks and a shallow return stack
`default_nettype none
module cdm_seq_model #(
   parameter int DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_take,
   input wire logic i_ret,
   output logic o_ack_slot,
   output logic o_stack_full
);
   timeunit 1ns;
   timeprecision 1ns;
   int depth;
   logic [1:0] phase;
   // an acknowledge point once per four cycles
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase <= 2'h0;
         depth <= 0;
      end else begin
         phase <= phase + 2'h1;
         if (i_take && depth < DEPTH) depth <= depth + 1;
         else if (i_ret && depth > 0) depth <= depth - 1;
      end
   end
   assign o_ack_slot = (phase == 2'h3);
   assign o_stack_full = (depth == DEPTH);
endmodule // cdm_seq_model
`default_nettype wire

// File: bench/test_core_data_memory_flags_irq.sv
// self-checking bench with a behavioural register model
`default_nettype none
module test_core_data_memory_flags_irq;
   timeunit 1ns;
   timeprecision 1ns;
   import cdm_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   cdm_avs_req_type avs = '0;
   cdm_alu_cmd_type alu = '0;
   cdm_bit_cmd_type bitc = '0;
   cdm_core_evt_type ev = '0;
   cdm_core_evt_type evt;
   logic pin_b = 1'b1;
   logic ack, full, take, wake, wr_wait;
   logic saw_wake = 1'b0;
   logic [31:0] rdata;
   logic [9:0] vec, last_vec;
   int error_cnt = 0;
   int n_compared = 0;
   int take_cnt = 0;
   int m_ptr = 0, m_w = 0, m_st = 0, m_ic = 0;
   int ram [64];
   always #20 i_clk = ~i_clk;
   always_comb begin
      evt = ev;
      evt.ack_slot = ack;
      evt.stack_full = full;
   end
   always @(posedge i_clk) begin
      if (take === 1'b1) begin
         take_cnt <= take_cnt + 1;
         last_vec <= vec;
      end
      if (wake === 1'b1) saw_wake <= 1'b1;
   end
   cdm_core_data_memory i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs(avs),
      .o_readdata(rdata), .o_waitrequest(wr_wait), .i_alu(alu), .i_bit(bitc), .i_evt(evt),
      .i_ext_irq_pin_b(pin_b), .o_irq_take(take), .o_irq_vector(vec), .o_wake(wake));
   cdm_seq_model #(.DEPTH(2)) i_seq (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_take(take),
      .i_ret(ev.irq_return), .o_ack_slot(ack), .o_stack_full(full));
   task automatic conclude();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input int exp, input logic [31:0] got);
      n_compared++;
      if (got !== 32'(exp)) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   function automatic int ea(int a);
      return (a == 0) ? m_ptr : a;
   endfunction
   function automatic int ld(int a);
      case (ea(a))
         0: return 0;
         1: return 8'h80 | m_ptr;
         5: return m_w;
         10: return m_st & 8'h3F;
         11: return m_ic & 8'h7F;
         default: return (ea(a) >= 64) ? ram[ea(a) - 64] : 0;
      endcase
   endfunction
   function automatic void st(int a, int d);
      case (ea(a))
         1: m_ptr = d & 8'h7F;
         5: m_w = d & 8'hFF;
         10: m_st = (m_st & 8'h30) | (d & 8'h0F);
         11: m_ic = d & 8'h7F;
         default: if (ea(a) >= 64) ram[ea(a) - 64] = d & 8'hFF;
      endcase
   endfunction
   task automatic bus(input logic w, input int a, input int d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge i_clk);
      avs <= '{read: !w, write: w, address: 9'(a * 4), writedata: 32'(d & 8'hFF)};
      do begin
         @(posedge i_clk);
         n++;
      end while (wr_wait !== 1'b0 && n < 40);
      if (n >= 40) begin
         $display("ERROR waitrequest expected 0 seen 1");
         error_cnt++;
      end
      q = rdata[7:0];
      avs <= '0;
   endtask
   task automatic wr(input int a, input int d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
      st(a, d);
   endtask
   task automatic rdc(input int a);
      logic [7:0] q;
      bus(1'b0, a, 0, q);
      chk($sformatf("addr %0h", a), ld(a), q);
   endtask
   task automatic pulse(input logic [7:0] m);
      ev <= cdm_core_evt_type'(m);
      @(posedge i_clk);
      ev <= '0;
      @(posedge i_clk);
   endtask
   task automatic bitop(input int a, input int p, input logic s);
      int v;
      bitc <= '{valid: 1'b1, set: s, addr: 7'(a), pos: 3'(p)};
      @(posedge i_clk);
      bitc <= '0;
      v = ld(a);
      st(a, s ? (v | (1 << p)) : (v & ~(1 << p)));
   endtask
   task automatic aluop(input int op, input int uc, input int a, input int b);
      int bb, ci, s, r, c, sw, hc;
      alu <= '{valid: 1'b1, op: cdm_alu_op_type'(5'(op)), use_carry: uc[0], a: 8'(a), b: 8'(b)};
      @(posedge i_clk);
      alu <= '0;
      bb = (op == 2) ? (~b & 8'hFF) : b;
      ci = uc ? (m_st & 1) : (op == 2);
      s = a + bb + ci;
      sw = (s >> 8) ^ (((a & 8'h7F) + (bb & 8'h7F) + ci) >> 7);
      hc = ((a & 8'h0F) + (bb & 8'h0F) + ci) >> 4;
      r = (op < 4) ? (s & 8'hFF) : (op == 4) ? a : (op == 8) ? (((a << 1) | (m_st & 1)) & 8'hFF)
         : ((a >> 1) | ((m_st & 1) << 7));
      c = (op < 4) ? (s >> 8) : (op == 8) ? (a >> 7) : (a & 1);
      if (op != 4) m_st = (m_st & ~1) | c;
      if (op < 4) m_st = (m_st & 8'h31) | (sw << 3) | (hc << 1);
      m_st = (m_st & ~4) | ((r == 0) << 2);
      m_w = r;
   endtask
   task automatic wait_take(input int v);
      int n0, n;
      n0 = take_cnt;
      n = 0;
      while (take_cnt == n0 && n < 60) begin
         @(posedge i_clk);
         n++;
      end
      chk("vector", v, 32'(last_vec));
   endtask
   initial begin
      repeat (30000) @(posedge i_clk);
      $display("ERROR watchdog expected finish seen timeout");
      error_cnt++;
      conclude();
   end
   initial begin
      int a, d, n;
      n = $urandom(32'h16BA10CB);
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clk);
      wr(0, 8'h55);
      wr(3, 8'hFF);
      for (a = 0; a < 12; a++) rdc(a);
      for (a = 64; a < 128; a++) wr(a, $urandom % 256);
      for (int i = 0; i < 150; i++) begin
         n = $urandom % 5;
         a = (n == 0) ? 0 : (n == 1) ? 1 : (n == 2) ? 5 + 5 * ($urandom % 2) : (n == 3)
            ? $urandom % 64 : 64 + $urandom % 64;
         d = $urandom % 256;
         if (ea(a) == 11) d = d & 8'hFE;
         if ($urandom % 2) wr(a, d);
         else rdc(a);
      end
      wr(1, 64 + $urandom % 64);
      for (int i = 0; i < 21; i++) begin
         a = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 5 : 64 + $urandom % 64;
         bitop(a, $urandom % 8, $urandom % 2);
         rdc(a);
      end
      for (int i = 0; i < 40; i++) begin
         if (i < 4) aluop(1 + i / 2, 0, (i == 0) ? 255 : (i == 1) ? 127 : 5 * (i == 2),
            1 + 4 * (i == 2));
         else aluop(1 << ($urandom % 5), $urandom % 2, $urandom % 256, $urandom % 256);
         rdc(5);
         rdc(10);
      end
      wr(11, 0);
      pulse(8'h20);
      m_st = m_st | 32;
      rdc(10);
      pulse(8'h80);
      m_st = (m_st | 16) & ~32;
      rdc(10);
      wr(10, 8'hFF);
      rdc(10);
      pulse(8'h40);
      m_st = m_st & ~48;
      rdc(10);
      pulse(8'h80);
      m_st = (m_st | 16) & ~32;
      wr(11, 8'h0E);
      pin_b <= 1'b0;
      pulse(8'h03);
      pin_b <= 1'b1;
      m_ic = 8'h7E;
      rdc(11);
      chk("wake", 1, 32'(saw_wake));
      wr(11, m_ic | 1);
      wait_take(4);
      m_ic = m_ic & ~8'h11;
      rdc(11);
      wr(11, m_ic | 1);
      wait_take(8);
      m_ic = m_ic & ~8'h21;
      wr(11, m_ic | 1);
      n = take_cnt;
      repeat (20) @(posedge i_clk);
      chk("takes", n, take_cnt);
      rdc(11);
      pulse(8'h10);
      wait_take(12);
      m_ic = m_ic & ~8'h41;
      rdc(11);
      pulse(8'h10);
      m_ic = m_ic | 1;
      rdc(11);
      conclude();
   end
endmodule // test_core_data_memory_flags_irq
`default_nettype wire
